// ---- shared/tatc_consts.vh ----
// Constants for the thermal alert and trip control block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef TATC_CONSTS_VH
`define TATC_CONSTS_VH
// Register offsets on the device's internal register port.
`define TATC_REG_CFG1 8'h01
`define TATC_REG_CFG2 8'h02
`define TATC_REG_CFG4 8'h04
`define TATC_REG_RATE 8'h05
`define TATC_REG_QUEUE 8'h06
`define TATC_REG_MASK1 8'h08
`define TATC_REG_MASK2 8'h09
`define TATC_REG_MASK3 8'h0A
`define TATC_REG_PCTLIM 8'h19
`define TATC_REG_HYST 8'h1A
`define TATC_REG_ONTIME 8'h4E
`define TATC_REG_STAT1 8'h4F
`define TATC_REG_STAT2 8'h50
`define TATC_REG_STAT3 8'h51
// Field positions.
`define TATC_CFG1_ALERT_COMP 3
`define TATC_CFG1_TIMER 2
`define TATC_CFG2_BOOST_DIS 1
`define TATC_CFG4_REF_SEL 7
`define TATC_MASK2_VALID 8'h1C
`define TATC_MASK3_VALID 8'hE0
// Reset values and the highest valid rate code.
`define TATC_RST_PCTLIM 8'hFF
`define TATC_RST_HYST 8'h04
`define TATC_RST_RATE 8'h08
`define TATC_RATE_MAX 8'h0A
// Timing: shortest on-time window in ms and the clock rate in kHz.
`define TATC_WIN_BASE_MS 250
`define TATC_CLK_KHZ 40000
`define TATC_WIN_BASE_CYC (`TATC_WIN_BASE_MS * `TATC_CLK_KHZ)
`endif

// ---- hdl/tatc_fault_queue.v ----
// Consecutive out-of-limit counter for one temperature channel.
// Assumes sampleStb pulses once per completed reading on the sys_clk domain.
`timescale 1ns/1ps
module tatc_fault_queue
(
   sys_clk,
   reset,
   clkEn,
   flush,
   sampleStb,
   outOfLimit,
   depth,
   full
);
input wire sys_clk;
input wire reset;
input wire clkEn;
input wire flush;
input wire sampleStb;
input wire outOfLimit;
input wire [2:0] depth;
output reg full;

reg [2:0] runCount_q;

// Counts consecutive bad readings and flags full at the programmed depth.
always @(posedge sys_clk or posedge reset)
begin
   if (reset)
   begin
      runCount_q <= 3'h0;
      full <= 1'b0;
   end
   else if (clkEn)
   begin
      if (flush)
      begin
         // Emptying the queue still admits a reading that lands in the same cycle.
         runCount_q <= {2'b00, sampleStb & outOfLimit}; // RQ11
         full <= sampleStb && outOfLimit && (depth == 3'h1);
      end
      else if (sampleStb)
      begin
         if (!outOfLimit)
            runCount_q <= 3'h0;
         else if (runCount_q < depth)
            runCount_q <= runCount_q + 3'h1;
         if (outOfLimit && (runCount_q + 3'h1 >= depth))
            full <= 1'b1; // RQ9
      end
   end
end
endmodule // tatc_fault_queue

// ---- hdl/tatc_ontime_timer.v ----
// On-time percentage meter for the trip input over a selectable window.
// Assumes lowIn is already synchronised to sys_clk.
`timescale 1ns/1ps
`include "tatc_consts.vh"
module tatc_ontime_timer
#(
   parameter BASE_CYC = `TATC_WIN_BASE_CYC
)
(
   sys_clk,
   reset,
   clkEn,
   enable,
   lowIn,
   winSel,
   percent,
   doneStb
);
input wire sys_clk;
input wire reset;
input wire clkEn;
input wire enable;
input wire lowIn;
input wire [2:0] winSel;
output reg [7:0] percent;
output reg doneStb;

reg [35:0] winCount_q;
reg [35:0] lowCount_q;
reg [35:0] winLen;
reg [43:0] scaled;
reg [43:0] quot;
// Base window held at the counter width, so every shifted length stays 36 bits wide.
localparam [35:0] BASE_LEN = BASE_CYC;

// Window length doubles per code step and saturates at 8 s.
always @*
begin
   winLen = BASE_LEN; // RQ18
   case (winSel)
      3'd0: winLen = BASE_LEN;
      3'd1: winLen = BASE_LEN << 1;
      3'd2: winLen = BASE_LEN << 2;
      3'd3: winLen = BASE_LEN << 3;
      3'd4: winLen = BASE_LEN << 4;
      default: winLen = BASE_LEN << 5;
   endcase
   scaled = {lowCount_q, 8'h00} - {8'h00, lowCount_q};
   // The low count stays below the window length, so the quotient never exceeds 255.
   quot = scaled / {8'h00, winLen};
end

// Counts low cycles inside each window and reports 255 * low / window.
always @(posedge sys_clk or posedge reset)
begin
   if (reset)
   begin
      winCount_q <= 36'h0_0000_0000;
      lowCount_q <= 36'h0_0000_0000;
      percent <= 8'h00;
      doneStb <= 1'b0;
   end
   else if (clkEn)
   begin
      doneStb <= 1'b0;
      if (!enable)
      begin
         winCount_q <= 36'h0_0000_0000;
         lowCount_q <= 36'h0_0000_0000;
      end
      else if (winCount_q + 36'h1 >= winLen)
      begin
         percent <= quot[7:0]; // RQ17
         doneStb <= 1'b1;
         winCount_q <= 36'h0_0000_0000;
         lowCount_q <= 36'h0_0000_0000;
      end
      else
      begin
         winCount_q <= winCount_q + 36'h1;
         if (lowIn)
            lowCount_q <= lowCount_q + 36'h1;
      end
   end
end
endmodule // tatc_ontime_timer

// ---- hdl/tatc_alert_trip.v ----
// Alert generation, masking, fault queues and over-temperature pin control.
// Assumes measurements, limits and register strobes come from sys_clk logic;
// the trip pin input and fan stall inputs arrive from outside and are synchronised.
`timescale 1ns/1ps
`include "tatc_consts.vh"
// Summary of operation
// RQ1 - Config 1 bit 3 selects latched alert (0) or comparator alert (1).
// RQ2 - Latched: status sets, unmasked source pulls alert low until read or response.
// RQ3 - Comparator: alert low while any measurement is out of limits, releases itself.
// RQ4 - Mask bits block only the alert; status bits still set.
// RQ5 - Mask 1 bits 7..0 cover the eight temperature sources.
// RQ6 - Mask 2 bits 4,3,2 cover percent, trip asserted, pin state.
// RQ7 - Mask 3 bits 7,6,5 cover fan stalls and alarm speed.
// RQ8 - Fan-fault pin shows stall unless config 4 bit 7 makes it a reference.
// RQ9 - Each temperature channel has a consecutive-reading fault queue in latched mode.
// RQ10 - Queue depth decodes 000X=1, 001X=2, 01XX=3, 1XXX=4.
// RQ11 - Alert response, status 1 read or reset empties the queues.
// RQ12 - Rate codes 0x00..0x0A double per step; higher codes reserved.
// RQ13 - Averaging below 16 per second; new rate applies after current loop.
// RQ14 - Output pin goes low at trip, releases below limit minus hysteresis.
// RQ15 - Trip forces fans full unless config 2 bit 1 disables boost.
// RQ16 - Config 1 bit 2 turns the trip pin into a timed input.
// RQ17 - Input low time measured as percent of window into register 0x4E.
// RQ18 - Window codes 0..4 give 0.25 s to 4 s; 5..7 give 8 s.
// RQ19 - Percent above limit sets status 2 bit 4; 0x00 first, 0xFF never.
// RQ20 - In input mode, enabled channels still pull the pin low on trip.
// RQ21 - Host reads status, masks source, acts, polls, then unmasks.
// RQ22 - High limit violated at greater or equal, low limit at strictly less.
// RQ23 - Status bits are sticky and clear on read only once condition is gone.
// RQ24 - Trip pin input is synchronised before edge detection or counting.
module tatc_alert_trip
#(
   parameter WIN_BASE_CYC = `TATC_WIN_BASE_CYC
)
(
   sys_clk,
   reset,
   clkEn,
   regWrEn,
   regRdEn,
   regAddr,
   regWrData,
   regRdData,
   alertResponse,
   sampleStb,
   loopDone,
   tempLocal,
   tempRemote1,
   tempRemote2,
   highLimits,
   lowLimits,
   tripLimits,
   diodeFault,
   fanOneStall,
   fanTwoStall,
   fanAlarmSpeed,
   trip_pin_in,
   alertN,
   overtempTripPinOut,
   overtempTripPinOe,
   fanFaultN,
   fanFaultRefMode,
   fanBoost,
   activeRate,
   averagingOn
);
input wire sys_clk;
input wire reset;
input wire clkEn;
input wire regWrEn;
input wire regRdEn;
input wire [7:0] regAddr;
input wire [7:0] regWrData;
output reg [7:0] regRdData;
input wire alertResponse;
input wire [2:0] sampleStb;
input wire loopDone;
input wire [7:0] tempLocal;
input wire [7:0] tempRemote1;
input wire [7:0] tempRemote2;
input wire [23:0] highLimits;
input wire [23:0] lowLimits;
input wire [23:0] tripLimits;
input wire [1:0] diodeFault;
input wire fanOneStall;
input wire fanTwoStall;
input wire fanAlarmSpeed;
input wire trip_pin_in;
output reg alertN;
output reg overtempTripPinOut;
output reg overtempTripPinOe;
output reg fanFaultN;
output reg fanFaultRefMode;
output reg fanBoost;
output reg [7:0] activeRate;
output reg averagingOn;

reg [7:0] cfg1_q, cfg2_q, cfg4_q, rate_q, queue_q, mask1_q, mask2_q, mask3_q;
reg [7:0] pctLimit_q, hyst_q;
reg [7:0] stat1_q, stat2_q, stat3_q;
reg [2:0] tripActive_q;
reg [2:0] fanSync1_q, fanSync2_q;
reg pinSync1_q, pinSync2_q;
reg alertLatch_q;
reg [7:0] stat1Cond;
reg [7:0] stat2Cond;
reg [7:0] stat3Cond;
reg [7:0] stat1Next, stat2Next, stat3Next;
reg [2:0] tripCond;
reg [2:0] tripHold;
reg pinLow;
wire compMode = cfg1_q[`TATC_CFG1_ALERT_COMP]; // RQ1
wire timerMode = cfg1_q[`TATC_CFG1_TIMER];
wire rd1 = regRdEn && (regAddr == `TATC_REG_STAT1);
wire rd2 = regRdEn && (regAddr == `TATC_REG_STAT2);
wire rd3 = regRdEn && (regAddr == `TATC_REG_STAT3);
wire queueFlush = alertResponse | rd1;
wire [2:0] queueFull;
wire [7:0] onPercent;
wire onDone;

// Decodes the fault queue depth field.
function [2:0] queueDepth;
   input [3:0] f;
   begin
      if (f[3])
         queueDepth = 3'd4; // RQ10
      else if (f[2])
         queueDepth = 3'd3;
      else if (f[1])
         queueDepth = 3'd2;
      else
         queueDepth = 3'd1;
   end
endfunction

// Sticky status update: set wins, read clears only when the cause has gone.
function [7:0] sticky;
   input [7:0] cur;
   input [7:0] cond;
   input rd;
   begin
      sticky = rd ? cond : (cur | cond); // RQ23
   end
endfunction
// Two flip-flop synchronisers for the trip pin and the fan inputs.
always @(posedge sys_clk or posedge reset)
begin
   if (reset)
   begin
      pinSync1_q <= 1'b1;
      pinSync2_q <= 1'b1;
      fanSync1_q <= 3'h0;
      fanSync2_q <= 3'h0;
   end
   else if (clkEn)
   begin
      pinSync1_q <= trip_pin_in; // RQ24
      pinSync2_q <= pinSync1_q;
      fanSync1_q <= {fanOneStall, fanAlarmSpeed, fanTwoStall};
      fanSync2_q <= fanSync1_q;
   end
end

// Limit comparisons for the three temperature channels.
always @*
begin
   pinLow = ~pinSync2_q;
   stat1Cond[7] = tempLocal >= highLimits[7:0]; // RQ22
   stat1Cond[6] = tempLocal < lowLimits[7:0];
   stat1Cond[5] = tempRemote1 >= highLimits[15:8];
   stat1Cond[4] = tempRemote1 < lowLimits[15:8];
   stat1Cond[3] = diodeFault[0];
   stat1Cond[2] = tempRemote2 >= highLimits[23:16];
   stat1Cond[1] = tempRemote2 < lowLimits[23:16];
   stat1Cond[0] = diodeFault[1];
   tripCond[0] = tempLocal >= tripLimits[7:0];
   tripCond[1] = tempRemote1 >= tripLimits[15:8];
   tripCond[2] = tempRemote2 >= tripLimits[23:16];
   // A trip stays active until the reading falls below limit minus hysteresis.
   tripHold[0] = tripCond[0] | (tripActive_q[0] & ({1'b0, tempLocal} + {1'b0, hyst_q} >=
      {1'b0, tripLimits[7:0]})); // RQ14
   tripHold[1] = tripCond[1] | (tripActive_q[1] & ({1'b0, tempRemote1} + {1'b0, hyst_q} >=
      {1'b0, tripLimits[15:8]}));
   tripHold[2] = tripCond[2] | (tripActive_q[2] & ({1'b0, tempRemote2} + {1'b0, hyst_q} >=
      {1'b0, tripLimits[23:16]}));
   stat2Cond = {tripCond[0], tripCond[1], tripCond[2], 1'b0, |tripActive_q & ~timerMode,
      timerMode & pinLow, 2'b00};
   stat2Cond[4] = onDone && (onPercent > pctLimit_q) && (pctLimit_q != 8'hFF); // RQ19
   stat3Cond = {fanSync2_q, 5'h00};
   // Next status values; masks never stop a bit from setting.
   stat1Next = sticky(stat1_q, stat1Cond, rd1 | alertResponse);
   stat2Next = sticky(stat2_q, stat2Cond, rd2 | alertResponse) | (stat2_q & 8'h10 & ~{8{rd2}});
   stat3Next = sticky(stat3_q, stat3Cond, rd3 | alertResponse);
end

// One fault queue per channel, fed only by unmasked sources so a masked one never fills it.
tatc_fault_queue uQueueLocal
(
   .sys_clk(sys_clk),
   .reset(reset),
   .clkEn(clkEn),
   .flush(queueFlush), // RQ11
   .sampleStb(sampleStb[0]),
   .outOfLimit(|(stat1Cond[7:6] & ~mask1_q[7:6])), // RQ4
   .depth(queueDepth(queue_q[3:0])),
   .full(queueFull[0])
);
tatc_fault_queue uQueueRemote1
(
   .sys_clk(sys_clk),
   .reset(reset),
   .clkEn(clkEn),
   .flush(queueFlush),
   .sampleStb(sampleStb[1]),
   .outOfLimit(|(stat1Cond[5:3] & ~mask1_q[5:3])),
   .depth(queueDepth(queue_q[3:0])),
   .full(queueFull[1])
);
tatc_fault_queue uQueueRemote2
(
   .sys_clk(sys_clk),
   .reset(reset),
   .clkEn(clkEn),
   .flush(queueFlush),
   .sampleStb(sampleStb[2]),
   .outOfLimit(|(stat1Cond[2:0] & ~mask1_q[2:0])),
   .depth(queueDepth(queue_q[3:0])),
   .full(queueFull[2])
);

// On-time meter runs only while the pin is an input.
tatc_ontime_timer #(.BASE_CYC(WIN_BASE_CYC)) uOnTime
(
   .sys_clk(sys_clk),
   .reset(reset),
   .clkEn(clkEn),
   .enable(timerMode),
   .lowIn(pinLow),
   .winSel(cfg4_q[6:4]), // RQ17
   .percent(onPercent),
   .doneStb(onDone)
);

// Register writes, sticky status, trip tracking and pin outputs.
always @(posedge sys_clk or posedge reset)
begin
   if (reset)
   begin
      cfg1_q <= 8'h00;
      cfg2_q <= 8'h00;
      cfg4_q <= 8'h00;
      rate_q <= `TATC_RST_RATE;
      activeRate <= `TATC_RST_RATE;
      averagingOn <= 1'b0;
      queue_q <= 8'h00;
      mask1_q <= 8'h00;
      mask2_q <= 8'h00;
      mask3_q <= 8'h00;
      pctLimit_q <= `TATC_RST_PCTLIM;
      hyst_q <= `TATC_RST_HYST;
      stat1_q <= 8'h00;
      stat2_q <= 8'h00;
      stat3_q <= 8'h00;
      tripActive_q <= 3'h0;
      alertLatch_q <= 1'b0;
      alertN <= 1'b1;
      overtempTripPinOut <= 1'b1;
      overtempTripPinOe <= 1'b0;
      fanFaultN <= 1'b1;
      fanFaultRefMode <= 1'b0;
      fanBoost <= 1'b0;
      regRdData <= 8'h00;
   end
   else if (clkEn)
   begin
      if (regWrEn)
      begin
         case (regAddr)
            `TATC_REG_CFG1: cfg1_q <= regWrData;
            `TATC_REG_CFG2: cfg2_q <= regWrData;
            `TATC_REG_CFG4: cfg4_q <= regWrData;
            `TATC_REG_RATE: if (regWrData <= `TATC_RATE_MAX) rate_q <= regWrData; // RQ12
            `TATC_REG_QUEUE: queue_q <= regWrData;
            `TATC_REG_MASK1: mask1_q <= regWrData; // RQ5
            `TATC_REG_MASK2: mask2_q <= regWrData & `TATC_MASK2_VALID; // RQ6
            `TATC_REG_MASK3: mask3_q <= regWrData & `TATC_MASK3_VALID; // RQ7
            `TATC_REG_PCTLIM: pctLimit_q <= regWrData;
            `TATC_REG_HYST: hyst_q <= regWrData;
            default: ;
         endcase
      end
      // A new rate takes effect only at the end of the running loop.
      if (loopDone)
      begin
         activeRate <= rate_q; // RQ13
         averagingOn <= rate_q < 8'h08;
      end
      // Status takes its next value; the latched alert looks at what stays pending after it.
      stat1_q <= stat1Next; // RQ4
      stat2_q <= stat2Next;
      stat3_q <= stat3Next;
      tripActive_q <= tripHold;
      // Latched alert: hold until read or response; queues replace temp sources.
      if ((|(queueFull & ~{3{queueFlush}})) || (|(stat2Next[4:2] & ~mask2_q[4:2])) ||
         (|(stat3Next[7:5] & ~mask3_q[7:5])))
         alertLatch_q <= 1'b1; // RQ2 RQ9
      else if (rd1 | rd2 | rd3 | alertResponse)
         alertLatch_q <= 1'b0;
      if (compMode)
         alertN <= ~((|(stat1Cond & ~mask1_q)) | (|(stat2Cond[4:3] & ~mask2_q[4:3])) |
            (|(stat3Cond[7:5] & ~mask3_q[7:5]))); // RQ3
      else
         alertN <= ~alertLatch_q;
      // Pin drive: output mode on any trip, input mode only on enabled channels.
      overtempTripPinOut <= 1'b0;
      overtempTripPinOe <= timerMode ? |(tripActive_q & cfg4_q[2:0]) : |tripActive_q; // RQ14 RQ16 RQ20
      fanBoost <= |tripActive_q & ~cfg2_q[`TATC_CFG2_BOOST_DIS]; // RQ15
      fanFaultRefMode <= cfg4_q[`TATC_CFG4_REF_SEL]; // RQ8
      fanFaultN <= cfg4_q[`TATC_CFG4_REF_SEL] | ~(fanSync2_q[2] | fanSync2_q[0]);
      case (regAddr)
         `TATC_REG_CFG1: regRdData <= cfg1_q;
         `TATC_REG_CFG2: regRdData <= cfg2_q;
         `TATC_REG_CFG4: regRdData <= cfg4_q;
         `TATC_REG_RATE: regRdData <= rate_q;
         `TATC_REG_QUEUE: regRdData <= queue_q;
         `TATC_REG_MASK1: regRdData <= mask1_q;
         `TATC_REG_MASK2: regRdData <= mask2_q;
         `TATC_REG_MASK3: regRdData <= mask3_q;
         `TATC_REG_PCTLIM: regRdData <= pctLimit_q;
         `TATC_REG_HYST: regRdData <= hyst_q;
         `TATC_REG_ONTIME: regRdData <= onPercent;
         `TATC_REG_STAT1: regRdData <= stat1_q;
         `TATC_REG_STAT2: regRdData <= stat2_q;
         `TATC_REG_STAT3: regRdData <= {stat3_q[7:5], 4'h0, ~alertN};
         default: regRdData <= 8'h00;
      endcase
   end
end
endmodule // tatc_alert_trip

// ---- verification/tatc_alert_monitor.sv ----
// Concurrent checks on the ports of the alert and trip block.
// Assumes a bind to tatc_alert_trip; configuration is mirrored from the write port.
`timescale 1ns/1ps
module tatc_alert_monitor
(
   input wire sys_clk,
   input wire reset,
   input wire clkEn,
   input wire regWrEn,
   input wire regRdEn,
   input wire [7:0] regAddr,
   input wire [7:0] regWrData,
   input wire alertResponse,
   input wire loopDone,
   input wire fanOneStall,
   input wire alertN,
   input wire overtempTripPinOe,
   input wire fanFaultN,
   input wire fanFaultRefMode,
   input wire fanBoost,
   input wire [7:0] activeRate,
   input wire averagingOn
);
reg [7:0] cfg1_q;
reg [7:0] cfg2_q;
reg [7:0] cfg4_q;
default clocking cb @(posedge sys_clk); endclocking
default disable iff (reset);
// Shadow copies of the configuration registers, so mode-dependent checks know the mode.
always @(posedge sys_clk or posedge reset)
begin
   if (reset)
   begin
      cfg1_q <= 8'h00;
      cfg2_q <= 8'h00;
      cfg4_q <= 8'h00;
   end
   else if (clkEn && regWrEn)
   begin
      if (regAddr == 8'h01) cfg1_q <= regWrData;
      if (regAddr == 8'h02) cfg2_q <= regWrData;
      if (regAddr == 8'h04) cfg4_q <= regWrData;
   end
end
property p_rateCap;
   activeRate <= 8'h0A;
endproperty
a_rateCap: assert property (p_rateCap) else $error("rate above top code");
property p_rateLoop;
   $changed(activeRate) |-> $past(loopDone) || $past(loopDone, 2);
endproperty
a_rateLoop: assert property (p_rateLoop) else $error("rate changed mid loop");
property p_avg;
   $stable(activeRate) |-> averagingOn == (activeRate < 8'h08);
endproperty
a_avg: assert property (p_avg) else $error("averaging wrong for rate");
property p_fanFault;
   (!cfg4_q[7] && fanOneStall) [*4] |-> !fanFaultN;
endproperty
a_fanFault: assert property (p_fanFault) else $error("stall not shown");
property p_refMode;
   $stable(cfg4_q) |-> fanFaultRefMode == cfg4_q[7];
endproperty
a_refMode: assert property (p_refMode) else $error("reference mode wrong");
property p_boostOff;
   cfg2_q[1] [*3] |-> !fanBoost;
endproperty
a_boostOff: assert property (p_boostOff) else $error("boost while disabled");
property p_timerOe;
   (cfg1_q[2] && cfg4_q[2:0] == 3'b000) [*3] |-> !overtempTripPinOe;
endproperty
a_timerOe: assert property (p_timerOe) else $error("pin driven as input");
property p_latchHold;
   !cfg1_q[3] && !alertN && !regRdEn && !alertResponse && !regWrEn
      && !$past(regRdEn) && !$past(alertResponse) |=> !alertN;
endproperty
a_latchHold: assert property (p_latchHold) else $error("latched alert let go");
c_alert: cover property ($fell(alertN));
c_trip: cover property ($rose(overtempTripPinOe));
c_rate: cover property ($changed(activeRate));
endmodule // tatc_alert_monitor

// ---- verification/tatc_trip_source.sv ----
// Far-side model of the trip pin: a pulled-up wire that an external sensor may pull low.
// Assumes the bench picks idle, held low, or toggling with a 200 ns period.
`timescale 1ns/1ps
module tatc_trip_source
(
   input wire logic oe,
   input wire logic [1:0] mode,
   output logic pinLevel
);
logic toggle = 1'b0;
// Square wave that reaches the wire only in toggling mode.
always #100 toggle = ~toggle;
// Wired level: the pull-up wins unless the block or the sensor pulls low.
assign pinLevel = !(oe || (mode == 2'd1) || ((mode == 2'd2) && toggle));
endmodule // tatc_trip_source

// ---- verification/tb_thermal_alert_and_trip_control.sv ----
// Self-checking bench for the alert and trip block, driven through its register port.
// Assumes a 40 MHz clock and a shortened on-time window of 100 cycles.
`timescale 1ns/1ps
module tb_thermal_alert_and_trip_control;
logic sys_clk = 1'b0;
logic reset = 1'b1;
logic regWrEn = 1'b0, regRdEn = 1'b0, alertResponse = 1'b0, loopDone = 1'b0;
logic fanOneStall = 1'b0, fanTwoStall = 1'b0, fanAlarm = 1'b0, clkEn = 1'b1;
logic [1:0] diodeFault = 2'b00, srcMode = 2'd0;
logic [2:0] sampleStb = 3'b000;
logic [7:0] regAddr = 8'h00, regWrData = 8'h00, tempLocal = 8'h40, tempRem = 8'h40;
logic [7:0] rdVal;
wire [7:0] regRdData, activeRate;
wire alertN, tripOut, tripOe, fanFaultN, refMode, fanBoost, avgOn, pinLvl;
wire [7:0] alertV = {7'h00, alertN};
wire [7:0] pinV = {5'h00, tripOut, tripOe, fanBoost};
int errTotal = 0;
int comparisons = 0;
// Clock at 40 MHz.
always #12.5 sys_clk = ~sys_clk;
tatc_alert_trip #(.WIN_BASE_CYC(100)) u_dut (.sys_clk(sys_clk), .reset(reset),
   .clkEn(clkEn), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
   .regWrData(regWrData), .regRdData(regRdData), .alertResponse(alertResponse),
   .sampleStb(sampleStb), .loopDone(loopDone), .tempLocal(tempLocal),
   .tempRemote1(tempRem), .tempRemote2(tempRem), .highLimits(24'h70_7070),
   .lowLimits(24'h10_1010), .tripLimits(24'h60_6060), .diodeFault(diodeFault),
   .fanOneStall(fanOneStall), .fanTwoStall(fanTwoStall), .fanAlarmSpeed(fanAlarm),
   .trip_pin_in(pinLvl), .alertN(alertN), .overtempTripPinOut(tripOut),
   .overtempTripPinOe(tripOe), .fanFaultN(fanFaultN), .fanFaultRefMode(refMode),
   .fanBoost(fanBoost), .activeRate(activeRate), .averagingOn(avgOn));
tatc_trip_source u_src (.oe(tripOe), .mode(srcMode), .pinLevel(pinLvl));
// Counts a comparison and reports a mismatch at once.
task chk(input logic [7:0] got, input logic [7:0] exp);
begin
   comparisons++;
   if (got !== exp)
   begin
      errTotal++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
   end
end
endtask
// One register write, held across one sampling edge.
task wr(input logic [7:0] a, input logic [7:0] d);
begin
   @(negedge sys_clk);
   regAddr = a;
   regWrData = d;
   regWrEn = 1'b1;
   @(negedge sys_clk);
   regWrEn = 1'b0;
end
endtask
// One register read; the masked answer is compared, then side effects settle.
task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
begin
   @(negedge sys_clk);
   regAddr = a;
   regRdEn = 1'b1;
   @(negedge sys_clk);
   regRdEn = 1'b0;
   rdVal = regRdData;
   chk(rdVal & m, e);
   repeat (2) @(negedge sys_clk);
end
endtask
// Pulses loop-end and reading strobes, then lets the outputs settle.
task stb(input logic [3:0] m);
begin
   @(negedge sys_clk);
   {loopDone, sampleStb} = m;
   @(negedge sys_clk);
   {loopDone, sampleStb} = 4'h0;
   repeat (3) @(negedge sys_clk);
end
endtask
// Prints the counts and the verdict, then stops.
task endOfTest;
begin
   $display("Comparisons %0d mismatches %0d", comparisons, errTotal);
   if (errTotal == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
   else
      $display("SIMULATION FAILED");
   $finish;
end
endtask
// Main sequence: reset, register map, rates, alerts, trip pin, fans, timer.
initial
begin
   repeat (5) @(negedge sys_clk);
   reset = 1'b0;
   rdc(8'h1A, 8'hFF, 8'h04);
   rdc(8'h19, 8'hFF, 8'hFF);
   rdc(8'h77, 8'hFF, 8'h00);
   wr(8'h09, 8'hFF);
   rdc(8'h09, 8'hFF, 8'h1C);
   wr(8'h0A, 8'hFF);
   rdc(8'h0A, 8'hFF, 8'hE0);
   wr(8'h08, 8'hA5);
   rdc(8'h08, 8'hFF, 8'hA5);
   // A write while the clock enable is low must leave the register untouched.
   clkEn = 1'b0;
   wr(8'h08, 8'h5A);
   clkEn = 1'b1;
   rdc(8'h08, 8'hFF, 8'hA5);
   for (int c = 0; c <= 10; c++)
   begin
      wr(8'h05, c[7:0]);
      rdc(8'h05, 8'hFF, c[7:0]);
   end
   chk(activeRate, 8'h08);
   stb(4'h8);
   chk({activeRate[6:0], avgOn}, 8'h14);
   wr(8'h05, 8'h05);
   stb(4'h8);
   chk({activeRate[6:0], avgOn}, 8'h0B);
   wr(8'h05, 8'h0B);
   rdc(8'h05, 8'hFF, 8'h05);
   // Fault queue depths 1 to 4 with a reading equal to the high limit.
   wr(8'h08, 8'h00);
   wr(8'h09, 8'h0C);
   for (int q = 0; q < 4; q++)
   begin
      wr(8'h06, 8'(1 << q));
      tempLocal = 8'h70;
      repeat (q) stb(4'h1);
      chk(alertV, 8'h01);
      stb(4'h1);
      chk(alertV, 8'h00);
      tempLocal = 8'h40;
      stb(4'h1);
      chk(alertV, 8'h00);
      rdc(8'h4F, 8'hFF, 8'h80);
      chk(alertV, 8'h01);
   end
   // Masked low-limit source still sets its status bit.
   wr(8'h06, 8'h00);
   wr(8'h08, 8'h40);
   tempLocal = 8'h10;
   stb(4'h1);
   rdc(8'h4F, 8'hFF, 8'h00);
   tempLocal = 8'h0F;
   stb(4'h1);
   chk(alertV, 8'h01);
   tempLocal = 8'h40;
   stb(4'h1);
   rdc(8'h4F, 8'hFF, 8'h40);
   rdc(8'h4F, 8'hFF, 8'h00);
   wr(8'h08, 8'h00);
   // Comparator mode: one reading suffices and recovery releases the alert.
   wr(8'h06, 8'h08);
   wr(8'h01, 8'h08);
   tempRem = 8'h75;
   stb(4'h6);
   chk(alertV, 8'h00);
   tempRem = 8'h40;
   stb(4'h6);
   chk(alertV, 8'h01);
   diodeFault = 2'b01;
   stb(4'h0);
   chk(alertV, 8'h00);
   diodeFault = 2'b00;
   stb(4'h0);
   chk(alertV, 8'h01);
   // Trip output with hysteresis and fan boost.
   wr(8'h01, 8'h00);
   rdc(8'h4F, 8'h00, 8'h00);
   wr(8'h08, 8'hFF);
   tempLocal = 8'h61;
   stb(4'h1);
   chk(pinV, 8'h03);
   tempLocal = 8'h5D;
   stb(4'h1);
   chk(pinV, 8'h03);
   tempLocal = 8'h5A;
   stb(4'h1);
   chk(pinV, 8'h00);
   wr(8'h02, 8'h02);
   tempLocal = 8'h61;
   stb(4'h1);
   chk(pinV, 8'h02);
   tempLocal = 8'h40;
   stb(4'h1);
   // Fan-fault pin and its reference function.
   fanOneStall = 1'b1;
   stb(4'h0);
   chk({7'h00, fanFaultN}, 8'h00);
   fanOneStall = 1'b0;
   fanTwoStall = 1'b1;
   stb(4'h0);
   chk({7'h00, fanFaultN}, 8'h00);
   wr(8'h04, 8'h80);
   stb(4'h0);
   chk({7'h00, refMode}, 8'h01);
   fanTwoStall = 1'b0;
   // Masked alarm-speed source sets its status bit but raises no alert.
   fanAlarm = 1'b1;
   stb(4'h0);
   chk(alertV, 8'h01);
   fanAlarm = 1'b0;
   rdc(8'h51, 8'h40, 8'h40);
   // Trip pin as timed input: full-scale limit, then a half-duty input.
   wr(8'h04, 8'h00);
   wr(8'h01, 8'h04);
   rdc(8'h50, 8'h00, 8'h00);
   rdc(8'h51, 8'h00, 8'h00);
   srcMode = 2'd1;
   repeat (300) @(negedge sys_clk);
   rdc(8'h50, 8'h10, 8'h00);
   wr(8'h19, 8'h20);
   srcMode = 2'd2;
   repeat (300) @(negedge sys_clk);
   srcMode = 2'd0;
   chk(alertV, 8'h00);
   rdc(8'h4E, 8'h00, 8'h00);
   chk({7'h00, (rdVal > 8'h60) && (rdVal < 8'hA0)}, 8'h01);
   rdc(8'h50, 8'h10, 8'h10);
   wr(8'h04, 8'h01);
   tempLocal = 8'h61;
   stb(4'h1);
   chk({7'h00, tripOe}, 8'h01);
   endOfTest;
end
endmodule // tb_thermal_alert_and_trip_control
bind tatc_alert_trip tatc_alert_monitor u_mon (.sys_clk(sys_clk), .reset(reset),
   .clkEn(clkEn), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
   .regWrData(regWrData), .alertResponse(alertResponse), .loopDone(loopDone),
   .fanOneStall(fanOneStall), .alertN(alertN), .overtempTripPinOe(overtempTripPinOe),
   .fanFaultN(fanFaultN), .fanFaultRefMode(fanFaultRefMode), .fanBoost(fanBoost),
   .activeRate(activeRate), .averagingOn(averagingOn));
